// ---- hw/asc_consts.svh ----
// Named constants for the converter scan control and status register block.
// Assumes inclusion by bare name from the package and the top module only.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// Register addresses
`define ASC_ADDR_CHSEL   4'h4
`define ASC_ADDR_SYSCFG  4'h5
`define ASC_ADDR_INTPWR  4'h6
`define ASC_ADDR_STATUS  4'h7
`define ASC_ADDR_TRIG    4'h8
`define ASC_ADDR_RESET   4'h9
`define ASC_RESET_KEY    8'hAA

// Serial commands, first two bits of a frame
`define ASC_CMD_READ     2'h1
`define ASC_CMD_WRITE    2'h2
`define ASC_CMD_ADC      2'h3

// Reset values
`define ASC_CHSEL_RST    3'h0
`define ASC_SYSCFG_RST   8'h00
`define ASC_IEN_RST      4'h0
`define ASC_TRIG_RST     3'h2
`define ASC_PIN_IDLE     1'h1

// System config field positions
`define ASC_CFG_AVG_HI   7
`define ASC_CFG_AVG_LO   5
`define ASC_CFG_PULSE    4
`define ASC_CFG_POL      3
`define ASC_CFG_BUSY     2
`define ASC_CFG_FIFO     1
`define ASC_CFG_RDCONV   0

// Trigger codes
`define ASC_TRIG_IDLE    3'h0
`define ASC_TRIG_MAN     3'h2
`define ASC_TRIG_MAN_DLY 3'h3
`define ASC_TRIG_AUTO    3'h4
`define ASC_TRIG_SCAN1   3'h5
`define ASC_TRIG_SCANN   3'h6

// Averaging counts
`define ASC_AVG_1        5'h01
`define ASC_AVG_4        5'h04
`define ASC_AVG_8        5'h08
`define ASC_AVG_16       5'h10

// Link bit counts, zero based edge index inside a frame
`define ASC_LNK_ADDR_BIT 5'h05
`define ASC_LNK_DATA_BIT 5'h07
`define ASC_LNK_WR_BIT   5'h0F
`define ASC_LNK_CNT_MAX  5'h1F

// Buffer geometry
`define ASC_FIFO_DEPTH   4'h8
`define ASC_LAST_CHAN    3'h7

// Interrupt pulse timing
`define ASC_INT_PULSE_NS 250
`define ASC_REF_PERIOD_NS 4
`define ASC_INT_PULSE_CYC ((`ASC_INT_PULSE_NS + `ASC_REF_PERIOD_NS - 1) / `ASC_REF_PERIOD_NS)

`endif

// ---- hw/asc_pkg.sv ----
// Types shared by the converter scan control block.
// Assumes the constants header sits beside it.
`include "asc_consts.svh"
package asc_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SEQ_READY = 2'h0,
    SEQ_CONV  = 2'h1,
    SEQ_DONE  = 2'h2
  } asc_seq_st_e;

  typedef logic [15:0] asc_word_t;

endpackage

// ---- hw/asc_sync2.sv ----
// Two flip-flop level synchroniser.
// Assumes the input is a level that stays put for at least two destination edges.
`timescale 1ns/1ns
module asc_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;

  // First stage is seen only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // asc_sync2

// ---- hw/asc_rbuf_mem.sv ----
// Eight entry result buffer storage with registered read data.
// Assumes pointers are managed by the caller; read data lag the address by one edge.
`timescale 1ns/1ns
module asc_rbuf_mem (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 wr_en_i,
  input  wire logic [2:0]           wr_addr_i,
  input  wire asc_pkg::asc_word_t   wr_data_i,
  input  wire logic [2:0]           rd_addr_i,
  output asc_pkg::asc_word_t        rd_data_o
);
  import asc_pkg::*;

  asc_word_t mem_q [8];

  // Storage has no reset; only the pointers give it meaning
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered head read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule // asc_rbuf_mem

// ---- hw/asc_top.sv ----
// Register set, conversion sequencer, result buffer control and serial port
// of an eight channel scanning converter.
// Assumes the analog core works on ref_clk_i, and the host clocks sclk_i only in frames.
`timescale 1ns/1ns
`include "asc_consts.svh"
module asc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Serial port from the host
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdin_i,
  output logic             sdout_o,
  output logic             sdout_oe_o,
  // Start pin
  input  wire logic        convert_start_pin_i,
  // Converter core
  input  wire logic        conv_busy_i,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_result_i,
  output logic             conv_start_o,
  output logic             conv_abort_o,
  output logic [2:0]       mux_chan_o,
  output logic             delay_mux_o,
  output logic [4:0]       avg_count_o,
  output logic             avg_accurate_o,
  output logic             power_down_o,
  // Shared busy or interrupt pin
  output logic             busy_int_o
);
  import asc_pkg::*;

  // Link domain
  logic        frame_rst_n;
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [5:0]  rq_q;
  logic [11:0] wr_q;
  logic [1:0]  tgl_q;
  asc_word_t   out_sh_q;
  // Core domain
  logic [1:0]  tgl_s;
  logic [1:0]  tgl_prev_q;
  logic        rq_evt;
  logic        wr_evt;
  logic        adc_rd;
  asc_word_t   rd_word_q;
  logic [2:0]  sel_q;
  logic [7:0]  cfg_q;
  logic        pd_q;
  logic [3:0]  ien_q;
  logic [2:0]  trig_q;
  logic        soft_rst_q;
  logic        pin_s;
  logic        pin_prev_q;
  logic        pin_rise;
  asc_seq_st_e st_q;
  logic [2:0]  chan_q;
  logic        done_evt;
  logic        is_manual;
  logic        is_auto;
  logic        is_scan;
  logic        start_req;
  logic        data_rdy_q;
  logic        scan_rdy_q;
  asc_word_t   last_q;
  asc_word_t   head;
  asc_word_t   res_word;
  logic [2:0]  wr_ptr_q;
  logic [2:0]  rd_ptr_q;
  logic [3:0]  level_q;
  logic        fifo_ne;
  logic        fifo_full;
  logic        push;
  logic        pop;
  logic [3:0]  src;
  logic        int_src;
  logic        int_src_q;
  logic [5:0]  pulse_cnt_q;
  logic        int_act;
  logic        shared;
  logic [7:0]  reg_rd;

  // Bit counter and input shifter live only for one frame
  assign frame_rst_n = reset_n_i & ~cs_n_i;

  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 15'h0000;
    end else begin
      if (bit_cnt_q != `ASC_LNK_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      shift_q <= {shift_q[13:0], sdin_i};
    end
  end

  // Request and write holds are posted by toggles; they survive the frame end
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rq_q  <= 6'h00;
      wr_q  <= 12'h000;
      tgl_q <= 2'h0;
    end else begin
      if (bit_cnt_q == `ASC_LNK_ADDR_BIT) begin
        rq_q <= {shift_q[4:0], sdin_i};
        if (shift_q[4:3] != `ASC_CMD_WRITE) begin
          tgl_q[0] <= ~tgl_q[0];
        end
      end
      if (bit_cnt_q == `ASC_LNK_WR_BIT && rq_q[5:4] == `ASC_CMD_WRITE) begin
        wr_q     <= {rq_q[3:0], shift_q[6:0], sdin_i};
        tgl_q[1] <= ~tgl_q[1];
      end
    end
  end

  // Answer word is read two link edges after the request toggle;
  // the core has it settled within four of its own cycles
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_sh_q <= 16'h0000;
    end else if (bit_cnt_q == `ASC_LNK_DATA_BIT) begin
      out_sh_q <= rd_word_q;
    end else if (bit_cnt_q > `ASC_LNK_DATA_BIT) begin
      out_sh_q <= {out_sh_q[14:0], 1'b0};
    end
  end

  assign sdout_o    = out_sh_q[15];
  assign sdout_oe_o = ~cs_n_i;

  // Toggles into the core domain
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tgl
      asc_sync2 u_sync (
        .clk_i   (ref_clk_i),
        .rst_n_i (reset_n_i),
        .d_i     (tgl_q[gi]),
        .q_o     (tgl_s[gi])
      );
    end
  endgenerate

  asc_sync2 u_pin_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (reset_n_i),
    .d_i     (convert_start_pin_i),
    .q_o     (pin_s)
  );

  // Event edges seen from synchronised levels only
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_prev_q <= 2'h0;
      pin_prev_q <= 1'b0;
    end else begin
      tgl_prev_q <= tgl_s;
      pin_prev_q <= pin_s;
    end
  end

  assign rq_evt   = tgl_s[0] ^ tgl_prev_q[0];
  assign wr_evt   = tgl_s[1] ^ tgl_prev_q[1];
  assign adc_rd   = rq_evt && (rq_q[5:4] == `ASC_CMD_ADC);
  assign pin_rise = pin_s & ~pin_prev_q;

  // Soft reset is refused in power-down
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_evt && wr_q[11:8] == `ASC_ADDR_RESET &&
                    wr_q[7:0] == `ASC_RESET_KEY && !pd_q;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q  <= `ASC_CHSEL_RST;
      cfg_q  <= `ASC_SYSCFG_RST;
      pd_q   <= 1'b0;
      ien_q  <= `ASC_IEN_RST;
      trig_q <= `ASC_TRIG_RST;
    end else if (soft_rst_q) begin
      sel_q  <= `ASC_CHSEL_RST;
      cfg_q  <= `ASC_SYSCFG_RST;
      pd_q   <= 1'b0;
      ien_q  <= `ASC_IEN_RST;
      trig_q <= `ASC_TRIG_RST;
    end else if (wr_evt) begin
      case (wr_q[11:8])
        `ASC_ADDR_CHSEL:  sel_q  <= wr_q[2:0];
        `ASC_ADDR_SYSCFG: cfg_q  <= wr_q[7:0];
        `ASC_ADDR_INTPWR: begin
          pd_q  <= wr_q[7];
          ien_q <= wr_q[3:0];
        end
        `ASC_ADDR_TRIG:   trig_q <= wr_q[2:0];
        default:          ;
      endcase
    end
  end

  // Mode decode; reserved codes simply start nothing
  assign is_manual = (trig_q == `ASC_TRIG_MAN) || (trig_q == `ASC_TRIG_MAN_DLY);
  assign is_auto   = (trig_q == `ASC_TRIG_AUTO);
  assign is_scan   = (trig_q == `ASC_TRIG_SCAN1) || (trig_q == `ASC_TRIG_SCANN);
  assign start_req = (is_manual && (cfg_q[`ASC_CFG_RDCONV] ? adc_rd : pin_rise))
                     || is_auto || is_scan;
  assign done_evt  = (st_q == SEQ_CONV) && conv_done_i;

  // Conversion sequencer and channel stepping
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q         <= SEQ_READY;
      chan_q       <= `ASC_CHSEL_RST;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (soft_rst_q) begin
        st_q   <= SEQ_READY;
        chan_q <= `ASC_CHSEL_RST;
      end else if (wr_evt && wr_q[11:8] == `ASC_ADDR_TRIG) begin
        // A conversion in flight still owns the core until its done
        st_q   <= (st_q == SEQ_CONV) ? SEQ_CONV : SEQ_READY;
        chan_q <= sel_q;
      end else begin
        case (st_q)
          SEQ_READY: begin
            if (!is_scan) begin
              chan_q <= sel_q;
            end
            if (start_req && !pd_q) begin
              st_q         <= SEQ_CONV;
              conv_start_o <= 1'b1;
            end
          end
          SEQ_CONV: begin
            if (conv_done_i) begin
              st_q <= SEQ_READY;
              if (is_scan) begin
                if (chan_q == `ASC_LAST_CHAN) begin
                  chan_q <= sel_q;
                  if (trig_q == `ASC_TRIG_SCAN1) begin
                    st_q <= SEQ_DONE;
                  end
                end else begin
                  chan_q <= chan_q + 3'h1;
                end
              end
            end
          end
          SEQ_DONE: ;
          default:  st_q <= SEQ_READY;
        endcase
      end
    end
  end

  // Ready flags; a new result beats a same-cycle read
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_rdy_q <= 1'b0;
      scan_rdy_q <= 1'b0;
    end else if (soft_rst_q) begin
      data_rdy_q <= 1'b0;
      scan_rdy_q <= 1'b0;
    end else begin
      if (done_evt) begin
        data_rdy_q <= 1'b1;
      end else if (adc_rd) begin
        data_rdy_q <= 1'b0;
      end
      if (done_evt && is_scan && chan_q == `ASC_LAST_CHAN) begin
        scan_rdy_q <= 1'b1;
      end else if (adc_rd) begin
        scan_rdy_q <= 1'b0;
      end
    end
  end

  // Result buffer pointers; a result into a full buffer is dropped
  assign res_word  = {1'b0, chan_q, conv_result_i};
  assign fifo_ne   = (level_q != 4'h0);
  assign fifo_full = (level_q == `ASC_FIFO_DEPTH);
  assign push      = done_evt && cfg_q[`ASC_CFG_FIFO] && !fifo_full;
  assign pop       = adc_rd && cfg_q[`ASC_CFG_FIFO] && fifo_ne;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      level_q  <= 4'h0;
    end else if (soft_rst_q) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      level_q  <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
      end
      if (push && !pop) begin
        level_q <= level_q + 4'h1;
      end else if (pop && !push) begin
        level_q <= level_q - 4'h1;
      end
    end
  end

  asc_rbuf_mem u_rbuf (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (push),
    .wr_addr_i (wr_ptr_q),
    .wr_data_i (res_word),
    .rd_addr_i (rd_ptr_q),
    .rd_data_o (head)
  );

  // Latest result when the buffer is bypassed
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_q <= 16'h0000;
    end else if (soft_rst_q) begin
      last_q <= 16'h0000;
    end else if (done_evt) begin
      last_q <= res_word;
    end
  end

  // Interrupt sources, each gated by its enable
  assign src     = {fifo_ne, fifo_full, scan_rdy_q, data_rdy_q};
  assign int_src = |(src & ien_q);

  // Register read mux; unused addresses read zero
  always_comb begin
    case (rq_q[3:0])
      `ASC_ADDR_CHSEL:  reg_rd = {5'h00, sel_q};
      `ASC_ADDR_SYSCFG: reg_rd = cfg_q;
      `ASC_ADDR_INTPWR: reg_rd = {pd_q, 3'h0, src & ien_q};
      `ASC_ADDR_STATUS: reg_rd = {level_q, fifo_ne, fifo_full,
                                  scan_rdy_q, data_rdy_q};
      `ASC_ADDR_TRIG:   reg_rd = {5'h00, trig_q};
      default:          reg_rd = 8'h00;
    endcase
  end

  // Answer word held until the next request
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_word_q <= 16'h0000;
    end else if (rq_evt) begin
      if (rq_q[5:4] == `ASC_CMD_ADC) begin
        rd_word_q <= (cfg_q[`ASC_CFG_FIFO] && fifo_ne) ? head : last_q;
      end else begin
        rd_word_q <= {reg_rd, 8'h00};
      end
    end
  end

  // Pulse stretcher; a source that stays high gives one pulse only
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_src_q   <= 1'b0;
      pulse_cnt_q <= 6'h00;
    end else begin
      int_src_q <= int_src;
      if (int_src && !int_src_q) begin
        pulse_cnt_q <= 6'(`ASC_INT_PULSE_CYC);
      end else if (pulse_cnt_q != 6'h00) begin
        pulse_cnt_q <= pulse_cnt_q - 6'h01;
      end
    end
  end

  assign int_act = cfg_q[`ASC_CFG_PULSE] ? (pulse_cnt_q != 6'h00) : int_src;
  assign shared  = cfg_q[`ASC_CFG_BUSY] ? conv_busy_i : int_act;

  // Core side outputs from flops
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_int_o     <= `ASC_PIN_IDLE;
      conv_abort_o   <= 1'b0;
      mux_chan_o     <= `ASC_CHSEL_RST;
      delay_mux_o    <= 1'b0;
      avg_count_o    <= `ASC_AVG_1;
      avg_accurate_o <= 1'b0;
      power_down_o   <= 1'b0;
    end else begin
      busy_int_o   <= cfg_q[`ASC_CFG_POL] ? shared : ~shared;
      conv_abort_o <= soft_rst_q;
      mux_chan_o   <= chan_q;
      delay_mux_o  <= (trig_q == `ASC_TRIG_MAN_DLY) || is_auto;
      power_down_o <= pd_q;
      case (cfg_q[`ASC_CFG_AVG_LO+1:`ASC_CFG_AVG_LO])
        2'h1:    avg_count_o <= `ASC_AVG_4;
        2'h2:    avg_count_o <= `ASC_AVG_8;
        2'h3:    avg_count_o <= `ASC_AVG_16;
        default: avg_count_o <= `ASC_AVG_1;
      endcase
      avg_accurate_o <= cfg_q[`ASC_CFG_AVG_HI] &&
                        (cfg_q[`ASC_CFG_AVG_LO+1:`ASC_CFG_AVG_LO] != 2'h0);
    end
  end
endmodule // asc_top

// ---- tb/asc_props.sv ----
// Assertions on the ports of the scan control block.
// Assumes it is bound into asc_top; one core clock domain.
`timescale 1ns/1ns
module asc_props (
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  input wire logic       conv_start_o,
  input wire logic       conv_abort_o,
  input wire logic       conv_done_i,
  input wire logic       power_down_o,
  input wire logic [2:0] mux_chan_o,
  input wire logic       delay_mux_o,
  input wire logic [4:0] avg_count_o,
  input wire logic       avg_accurate_o,
  input wire logic       busy_int_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Start is a strobe, and only one conversion is outstanding
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start strobe too long");
  one_pending_a: assert property (conv_start_o |=> !conv_start_o until (conv_done_i || conv_abort_o))
    else $error("start while conversion outstanding");
  // Soft reset restores defaults right behind the abort strobe
  abort_pulse_a: assert property (conv_abort_o |=> !conv_abort_o)
    else $error("abort strobe too long");
  abort_defaults_a: assert property (conv_abort_o |-> ##[0:2]
    (mux_chan_o == 3'h0 && !delay_mux_o && avg_count_o == 5'h01 && !avg_accurate_o))
    else $error("defaults not restored after abort");
  pd_no_abort_a: assert property (power_down_o |-> !conv_abort_o)
    else $error("soft reset taken in power-down");
  pd_no_start_a: assert property (power_down_o |-> !conv_start_o)
    else $error("conversion started in power-down");
  // Averaging outputs only take legal counts
  avg_legal_a: assert property (avg_count_o inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("illegal averaging count");
  avg_mode_a: assert property (avg_accurate_o |-> avg_count_o != 5'h01)
    else $error("accurate mode without averaging");
  // Shared pin inactive right after reset
  idle_pin_a: assert property (!$past(reset_n_i) |-> busy_int_o)
    else $error("shared pin active after reset");
endmodule // asc_props

bind asc_top asc_props props_u (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .conv_start_o(conv_start_o),
  .conv_abort_o(conv_abort_o), .conv_done_i(conv_done_i), .power_down_o(power_down_o),
  .mux_chan_o(mux_chan_o), .delay_mux_o(delay_mux_o), .avg_count_o(avg_count_o),
  .avg_accurate_o(avg_accurate_o), .busy_int_o(busy_int_o)
);

// ---- tb/asc_host_model.sv ----
// Host serial controller model making framed transfers.
// Assumes the block samples sdin on rising sclk and shifts sdout after it.
`timescale 1ns/1ns
module asc_host_model (
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     sdin_o,
  input wire logic sdout_i
);
  // Clock stands still outside frames
  initial begin
    // Select dips at time zero so the frame clear sees a falling edge
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    sdin_o = 1'b0;
    #1 cs_n_o = 1'b1;
  end
  // One frame of n edges, MSB first; answer taken from edge 9 on
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #3 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin_o = (i < 16) ? w[15-i] : ~sdin_o;
      // Sample just before the rising edge, where the bit has settled
      #8;
      if (i >= 8) rx = {rx[14:0], sdout_i};
      sclk_o = 1'b1;
      #7 sclk_o = 1'b0;
    end
    #8 cs_n_o = 1'b1;
    // Stale bit inverted so it cannot pass for data
    sdin_o = ~sdin_o;
    #60;
  endtask
endmodule // asc_host_model

// ---- tb/tb_adc_scan_config_status_regs.sv ----
// Self-checking bench for the scan control block.
// Assumes the host model file and the checker are compiled before it.
`timescale 1ns/1ns
module tb_adc_scan_config_status_regs;
  logic        ref_clk_i, reset_n_i, sclk, cs_n, sdin, sdout, sdout_oe;
  logic        pin, busy, done, start, abort, dmux, acc, pd, bint;
  logic [11:0] res, r0;
  logic [2:0]  chan;
  logic [4:0]  avg, ea;
  logic [3:0]  cnt;
  logic [15:0] rx;
  logic [2:0]  tc [6] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h2, 3'h0};
  int          fail_count, tests_run;

  asc_top dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdin_i(sdin), .sdout_o(sdout), .sdout_oe_o(sdout_oe),
    .convert_start_pin_i(pin), .conv_busy_i(busy), .conv_done_i(done),
    .conv_result_i(res), .conv_start_o(start), .conv_abort_o(abort),
    .mux_chan_o(chan), .delay_mux_o(dmux), .avg_count_o(avg),
    .avg_accurate_o(acc), .power_down_o(pd), .busy_int_o(bint));
  asc_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdin_o(sdin), .sdout_i(sdout));

  initial ref_clk_i = 1'b0;
  always #2 ref_clk_i = ~ref_clk_i;

  // Converter core: six cycles per conversion, results count up from 1
  always @(posedge ref_clk_i) begin
    done <= 1'b0;
    if (start) begin
      cnt <= 4'h6;
      busy <= 1'b1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        done <= 1'b1;
        busy <= 1'b0;
        res <= res + 12'h001;
      end
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.xfer({2'b10, a, 2'b00, d}, 16, rx);
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    host_u.xfer({2'b01, a, 10'h000}, 16, rx);
    @(negedge ref_clk_i);
    check(rx, e);
  endtask
  // Start pin held at least four core cycles per level
  task automatic fire;
    tick(1);
    pin <= 1'b1;
    tick(4);
    pin <= 1'b0;
    tick(14);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {pin, busy, done, res, cnt} = '0;
    fail_count = 0;
    tests_run = 0;
    // Reset falls after time zero so every async clear sees its edge
    reset_n_i = 1'b1;
    #1 reset_n_i = 1'b0;
    tick(6);
    reset_n_i <= 1'b1;
    tick(6);
    @(negedge ref_clk_i);
    check(16'(bint), 16'h0001);
    check(16'(avg), 16'h0001);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0002);
    rd(4'hB, 16'h0000);
    // Config registers only touched while idle
    wr(4'h8, 8'h00);
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0000);
    rd(4'h7, 16'h0000);
    $display("test reset done");
    wr(4'h4, 8'h05);
    rd(4'h4, 16'h0005);
    for (int c = 0; c < 8; c++) begin
      wr(4'h5, {3'(c), 5'h00});
      ea = (c % 4 == 0) ? 5'h01 : 5'(2 << (c % 4));
      check(16'(avg), 16'(ea));
      check(16'(acc), 16'(c > 4));
    end
    $display("test average done");
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h0F);
    wr(4'h8, 8'h02);
    check(16'(chan), 16'h0005);
    repeat (9) fire;
    wr(4'h8, 8'h00);
    rd(4'h7, 16'h008D);
    rd(4'h6, 16'h000D);
    check(16'(bint), 16'h0000);
    host_u.xfer(16'hC000, 24, rx);
    check(rx, 16'h5001);
    rd(4'h7, 16'h0078);
    $display("test buffer done");
    wr(4'h5, 8'h0A);
    check(16'(bint), 16'h0001);
    wr(4'h5, 8'h06);
    check(16'(bint), 16'h0001);
    wr(4'h5, 8'h02);
    check(16'(bint), 16'h0000);
    $display("test pin done");
    // Codes exclude the reserved ones
    for (int i = 0; i < 6; i++) begin
      wr(4'h8, {5'h00, tc[i]});
      rd(4'h8, 16'(tc[i]));
      check(16'(dmux), 16'(tc[i] == 3'h3 || tc[i] == 3'h4));
    end
    $display("test trigger done");
    wr(4'h9, 8'hAA);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0002);
    wr(4'h8, 8'h00);
    rd(4'h7, 16'h0000);
    rd(4'h5, 16'h0000);
    $display("test soft reset done");
    wr(4'h4, 8'h05);
    wr(4'h6, 8'h03);
    wr(4'h8, 8'h05);
    tick(150);
    wr(4'h8, 8'h00);
    rd(4'h7, 16'h0003);
    rd(4'h6, 16'h0003);
    check(16'(bint), 16'h0000);
    $display("test scan done");
    // Pulse style: a held source gives no pulse, a fresh one gives one
    wr(4'h5, 8'h18);
    check(16'(bint), 16'h0000);
    host_u.xfer(16'hC000, 24, rx);
    wr(4'h8, 8'h02);
    fire;
    @(negedge ref_clk_i);
    check(16'(bint), 16'h0001);
    tick(70);
    @(negedge ref_clk_i);
    check(16'(bint), 16'h0000);
    wr(4'h8, 8'h00);
    rd(4'h6, 16'h0001);
    $display("test pulse done");
    // Result reads start conversions; the first answer is thrown away
    wr(4'h5, 8'h01);
    wr(4'h8, 8'h02);
    host_u.xfer(16'hC000, 24, rx);
    r0 = res;
    host_u.xfer(16'hC000, 24, rx);
    check(rx, {4'h5, r0});
    wr(4'h8, 8'h00);
    $display("test read start done");
    wr(4'h6, 8'h80);
    check(16'(pd), 16'h0001);
    wr(4'h9, 8'hAA);
    rd(4'h6, 16'h0080);
    wr(4'h6, 8'h00);
    check(16'(pd), 16'h0000);
    $display("test power down done");
    complete_run;
  end

  // Watchdog well past the expected run length
  initial begin
    #400000;
    fail_count++;
    complete_run;
  end
endmodule // tb_adc_scan_config_status_regs
